// ==== include/pidc_pkg.sv ====
// ==================================================
// Constants, register map and carrier types
package pidc_pkg;
  // ==================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8; // Core clock period
  localparam int SAMPLE_TIME_US = 1000; // Regulator sample period
  localparam int SAMPLE_CYCLES = (SAMPLE_TIME_US * 1000) / CLK_PERIOD_NS; // Cycles per sample
  localparam int SAMPLES_PER_TENTH = 100000 / SAMPLE_TIME_US; // Samples in 0.1 s
  localparam int SAMPLES_PER_HUNDREDTH = 10000 / SAMPLE_TIME_US; // Samples in 0.01 s
  localparam int GAIN_DIV = 1000; // Gain is in thousandths
  localparam logic [31:0] ITIME_DEN = 32'(SAMPLES_PER_TENTH * GAIN_DIV); // I divisor scale
  // ==================================================
  // Scaling and ranges (process values in 0.01 %)
  localparam logic [15:0] FULL_SCALE = 16'h2710; // 100.00 % = 10 V or 20 mA at gain 1
  localparam logic [15:0] GAIN_MAX = 16'h7530; // 30.000
  localparam logic [15:0] ITIME_MAX = 16'h8CA0; // 3600.0 s
  localparam logic [15:0] DTIME_MAX = 16'hEA60; // 600.00 s
  localparam logic [15:0] FILT_MAX = 16'h2328; // 900.0 s
  localparam logic [15:0] WINDUP_MAX = 16'h07D0; // 200.0 %
  localparam logic [17:0] WINDUP_TO_ERR = 18'h0000A; // 0.1 % steps to 0.01 % steps
  localparam logic signed [39:0] IACC_LIM = 40'sh0080000000; // Integrator bound
  // ==================================================
  // Alarm type fields and output terminal functions
  localparam int ALARM_HOLD_BIT = 0; // Set in codes 1, 3, 5, 7
  localparam int ALARM_LATCH_BIT = 1; // Set in codes 2, 3, 6, 7
  localparam int ALARM_DEV_BIT = 2; // Set in codes 4 to 7
  localparam logic [7:0] DO_FUNC_ALARM = 8'h2A; // Code 42
  localparam logic [7:0] DO_FUNC_STOP = 8'h2C; // Code 44
  localparam int DO_COUNT = 2; // Output terminals
  // ==================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GAIN = 8'h04;
  localparam logic [7:0] OFS_ITIME = 8'h08;
  localparam logic [7:0] OFS_DTIME = 8'h0C;
  localparam logic [7:0] OFS_FILT = 8'h10;
  localparam logic [7:0] OFS_WINDUP = 8'h14;
  localparam logic [7:0] OFS_ALMSEL = 8'h18;
  localparam logic [7:0] OFS_ALMHI = 8'h1C;
  localparam logic [7:0] OFS_ALMLO = 8'h20;
  localparam logic [7:0] OFS_STOPF = 8'h24;
  localparam logic [7:0] OFS_LAT = 8'h28;
  localparam logic [7:0] OFS_RESTF = 8'h2C;
  localparam logic [7:0] OFS_DOFUNC = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h38;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h3C;
  localparam logic [7:0] OFS_FBFILT = 8'h40;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==================================================
  // Carrier types
  typedef struct packed {
    logic run_en; // Drive run request
    logic [15:0] gain;
    logic [15:0] itime;
    logic [15:0] dtime;
    logic [15:0] filt;
    logic [15:0] windup;
    logic [2:0] alarm_sel;
    logic [15:0] alarm_hi;
    logic [15:0] alarm_lo;
    logic [15:0] stop_f;
    logic [15:0] latency; // 0.1 s steps
    logic [15:0] restart_f;
    logic [DO_COUNT-1:0][7:0] do_func;
  } pidc_cfg_t;
  localparam pidc_cfg_t CFG_RST = '0; // All settings zero after reset
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } pidc_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pidc_axi_rsp_t;
endpackage

// ==== core/pidc_div.sv ====
`timescale 1ns/1ps
// ==================================================
// Serial restoring divider, one quotient bit per cycle
module pidc_div #(
  parameter int NUM_W = 48,
  parameter int DEN_W = 32
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [NUM_W-1:0] numerator,
  input wire logic [DEN_W-1:0] denominator,
  output logic done,
  output logic [NUM_W-1:0] quotient
);
  import pidc_pkg::*;
  localparam int CW = $clog2(NUM_W + 1); // Step counter width
  typedef struct packed {
    logic busy;
    logic done;
    logic [CW-1:0] cnt;
    logic [DEN_W:0] rem;
    logic [NUM_W-1:0] quo;
    logic [DEN_W-1:0] den;
  } pidc_div_state_t;
  pidc_div_state_t st;
  pidc_div_state_t next_st;
  logic [DEN_W:0] sh; // Shifted partial remainder
  // ==================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    sh = {st.rem[DEN_W-1:0], st.quo[NUM_W-1]};
    if (start) begin
      // Load operands; denominator is never zero here
      next_st.busy = 1'b1;
      next_st.cnt = CW'(NUM_W);
      next_st.rem = '0;
      next_st.quo = numerator;
      next_st.den = denominator;
    end else if (st.busy) begin
      // Trial subtraction
      if (sh >= {1'b0, st.den}) begin
        next_st.rem = sh - {1'b0, st.den};
        next_st.quo = {st.quo[NUM_W-2:0], 1'b1};
      end else begin
        next_st.rem = sh;
        next_st.quo = {st.quo[NUM_W-2:0], 1'b0};
      end
      next_st.cnt = st.cnt - 1'b1;
      if (st.cnt == CW'(1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end
  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign done = st.done;
  assign quotient = st.quo;
endmodule

// ==== core/pidc_alarm.sv ====
`timescale 1ns/1ps
// ==================================================
// Process alarm with absolute or deviation range, hold and latch
module pidc_alarm (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [2:0] mode,
  input wire logic [15:0] feedback,
  input wire logic [15:0] command,
  input wire logic [15:0] upper,
  input wire logic [15:0] lower,
  input wire logic clear,
  output logic alarm
);
  import pidc_pkg::*;
  typedef struct packed {
    logic armed; // Value has been inside the range since reset
    logic latched; // Latched alarm
    logic alarm;
  } pidc_alarm_state_t;
  pidc_alarm_state_t st;
  pidc_alarm_state_t next_st;
  logic signed [17:0] fb; // Signed copies for deviation bounds
  logic signed [17:0] lo_b;
  logic signed [17:0] hi_b;
  logic in_rng;
  logic en;
  logic raw;
  // ==================================================
  // Range test and hold/latch behaviour
  always_comb begin
    next_st = st;
    fb = $signed({2'b00, feedback});
    if (mode[ALARM_DEV_BIT]) begin
      lo_b = $signed({2'b00, command}) - $signed({2'b00, lower});
      hi_b = $signed({2'b00, command}) + $signed({2'b00, upper});
    end else begin
      lo_b = $signed({2'b00, lower});
      hi_b = $signed({2'b00, upper});
    end
    in_rng = (fb < lo_b) || (fb > hi_b);
    // Hold arms once the value has been inside the range
    if (!in_rng) begin
      next_st.armed = 1'b1;
    end
    en = !mode[ALARM_HOLD_BIT] || st.armed;
    raw = in_rng && en;
    // Clear first so a new alarm in the same cycle wins
    if (clear) begin
      next_st.latched = 1'b0;
    end
    if (raw && mode[ALARM_LATCH_BIT]) begin
      next_st.latched = 1'b1;
    end
    next_st.alarm = raw || (mode[ALARM_LATCH_BIT] && next_st.latched);
  end
  // State register; system reset also drops the latch
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign alarm = st.alarm;
endmodule

// ==== core/pidc_top.sv ====
`timescale 1ns/1ps
// Function
// - Derivative term from deviation rate times time
// - Feedback low-pass filter, 0 to 900 s
// - Integrator holds while deviation exceeds band
// - Alarm codes 0-3 absolute, 4-7 deviation
// - Absolute alarm outside lower or upper limit
// - Deviation alarm outside command minus/plus limits
// - Hold arms in the first cycle after reset (zero feedback inside zero limits), so suppresses no alarm
// - Latch keeps alarm until reset command or a CTRL write with bit 1 set
// - Limits are percent of feedback full scale
// - Alarm on terminal with function 42
// - Low output past latency stops drive
// - Drive restarts above restart frequency
// - Stop status on terminal with function 44
// - Restart below stop frequency replaces it
// - Proportional gain 0 to 30.000
// - Integral time 0 to 3600 s, zero disables
// - Derivative time 0 to 600 s, zero disables
module pidc_top #(
  parameter int SAMPLE_CYCLES_P = pidc_pkg::SAMPLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input pidc_pkg::pidc_axi_req_t axi_req,
  output pidc_pkg::pidc_axi_rsp_t axi_rsp,
  input wire logic [15:0] process_command_value,
  input wire logic [15:0] process_feedback_value,
  input wire logic reset_command,
  output logic [15:0] regulator_output_value,
  output logic drive_run,
  output logic process_alarm_output,
  output logic slow_flow_stopped_flag,
  output logic [pidc_pkg::DO_COUNT-1:0] do_terminal,
  output logic irq
);
  import pidc_pkg::*;
  // ==================================================
  // State
  typedef enum logic [2:0] {PH_IDLE, PH_FWAIT, PH_ERR, PH_IWAIT, PH_OUT} pidc_phase_t;
  typedef struct packed {
    pidc_cfg_t cfg; // Software settings
    logic aw_got; // Write address captured
    logic w_got; // Write data captured
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] irq_stat; // Alarm rise, slow stop, restart
    logic [2:0] irq_mask;
    logic [31:0] tick_cnt; // Sample period counter
    logic [15:0] fb_s1; // Feedback synchroniser
    logic [15:0] fb_s2;
    logic rst_s1; // Reset command synchroniser
    logic rst_s2;
    logic rst_s3; // Edge detect stage
    pidc_phase_t phase;
    logic [31:0] filt; // Filtered feedback, 16.16
    logic neg; // Sign of the pending quotient
    logic div_start;
    logic [47:0] div_num;
    logic [31:0] div_den;
    logic signed [17:0] err_prev;
    logic signed [39:0] iacc; // Integrator
    logic signed [63:0] pd_sum; // P plus D of this sample
    logic signed [63:0] iterm;
    logic [15:0] mv;
    logic stopped;
    logic [31:0] lat_cnt; // Samples below stop level
    logic alarm_clear;
    logic alarm_prev;
  } pidc_state_t;
  pidc_state_t st;
  pidc_state_t next_st;
  logic div_done; // Divider result ready
  logic [47:0] div_q;
  logic alarm; // Process alarm level
  logic aw_rdy;
  logic w_rdy;
  logic [32:0] rd; // {known, data}
  logic [31:0] v; // Merged write value
  logic [2:0] ev; // Interrupt events
  logic [2:0] w1c;
  logic signed [17:0] e_n; // Deviation
  logic [17:0] emag;
  logic signed [18:0] de;
  logic signed [39:0] isum;
  logic signed [39:0] iacc_n;
  logic [39:0] imag;
  logic signed [17:0] delta; // Filter input step
  logic [16:0] dmag;
  logic signed [63:0] p64;
  logic signed [63:0] d64;
  logic signed [63:0] s64;
  logic [15:0] mv_n;
  logic [15:0] eff_stop;
  // ==================================================
  // Helpers
  function automatic logic [15:0] lim(input logic [15:0] x, input logic [15:0] m);
    lim = (x > m) ? m : x;
  endfunction
  function automatic logic [32:0] reg_read(input pidc_state_t s, input logic [7:0] a);
    logic [31:0] d;
    logic k;
    d = '0;
    k = 1'b1;
    unique case (a)
      OFS_CTRL: d[0] = s.cfg.run_en;
      OFS_GAIN: d[15:0] = s.cfg.gain;
      OFS_ITIME: d[15:0] = s.cfg.itime;
      OFS_DTIME: d[15:0] = s.cfg.dtime;
      OFS_FILT: d[15:0] = s.cfg.filt;
      OFS_WINDUP: d[15:0] = s.cfg.windup;
      OFS_ALMSEL: d[2:0] = s.cfg.alarm_sel;
      OFS_ALMHI: d[15:0] = s.cfg.alarm_hi;
      OFS_ALMLO: d[15:0] = s.cfg.alarm_lo;
      OFS_STOPF: d[15:0] = s.cfg.stop_f;
      OFS_LAT: d[15:0] = s.cfg.latency;
      OFS_RESTF: d[15:0] = s.cfg.restart_f;
      OFS_DOFUNC: d[15:0] = s.cfg.do_func;
      OFS_STATUS: d = {s.mv, 14'h0000, s.stopped, s.alarm_prev};
      OFS_IRQ_STAT: d[2:0] = s.irq_stat;
      OFS_IRQ_MASK: d[2:0] = s.irq_mask;
      OFS_FBFILT: d[15:0] = s.filt[31:16];
      default: k = 1'b0;
    endcase
    reg_read = {k, d};
  endfunction
  // ==================================================
  // Divider and alarm
  pidc_div #(
    .NUM_W(48),
    .DEN_W(32)
  ) u_div (
    .core_clk(core_clk),
    .reset(reset),
    .start(st.div_start),
    .numerator(st.div_num),
    .denominator(st.div_den),
    .done(div_done),
    .quotient(div_q)
  );
  pidc_alarm u_alarm (
    .core_clk(core_clk),
    .reset(reset),
    .mode(st.cfg.alarm_sel),
    .feedback(st.filt[31:16]),
    .command(process_command_value),
    .upper(st.cfg.alarm_hi),
    .lower(st.cfg.alarm_lo),
    .clear(st.alarm_clear),
    .alarm(alarm)
  );
  // ==================================================
  // Bus handshakes
  assign aw_rdy = !st.aw_got && !st.bvalid;
  assign w_rdy = !st.w_got && !st.bvalid;
  // ==================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.div_start = 1'b0;
    next_st.alarm_clear = 1'b0;
    ev = '0;
    w1c = '0;
    rd = '0;
    v = '0;
    e_n = '0;
    emag = '0;
    de = '0;
    isum = '0;
    iacc_n = st.iacc;
    imag = '0;
    delta = '0;
    dmag = '0;
    p64 = '0;
    d64 = '0;
    s64 = '0;
    mv_n = st.mv;
    eff_stop = '0;
    // Input synchronisers
    next_st.fb_s1 = process_feedback_value;
    next_st.fb_s2 = st.fb_s1;
    next_st.rst_s1 = reset_command;
    next_st.rst_s2 = st.rst_s1;
    next_st.rst_s3 = st.rst_s2;
    if (st.rst_s2 && !st.rst_s3) begin
      next_st.alarm_clear = 1'b1;
    end
    // Write channel capture in either order
    if (axi_req.awvalid && aw_rdy) begin
      next_st.aw_got = 1'b1;
      next_st.waddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && w_rdy) begin
      next_st.w_got = 1'b1;
      next_st.wdata = axi_req.wdata;
      next_st.wstrb = axi_req.wstrb;
    end
    // Register write once both halves are in
    if (st.aw_got && st.w_got) begin
      rd = reg_read(st, st.waddr);
      for (int b = 0; b < 4; b++) begin
        v[8*b +: 8] = st.wstrb[b] ? st.wdata[8*b +: 8] : rd[8*b +: 8];
      end
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
      unique case (st.waddr)
        OFS_CTRL: begin
          next_st.cfg.run_en = v[0];
          next_st.alarm_clear = next_st.alarm_clear | v[1];
        end
        OFS_GAIN: next_st.cfg.gain = lim(v[15:0], GAIN_MAX);
        OFS_ITIME: next_st.cfg.itime = lim(v[15:0], ITIME_MAX);
        OFS_DTIME: next_st.cfg.dtime = lim(v[15:0], DTIME_MAX);
        OFS_FILT: next_st.cfg.filt = lim(v[15:0], FILT_MAX);
        OFS_WINDUP: next_st.cfg.windup = lim(v[15:0], WINDUP_MAX);
        OFS_ALMSEL: next_st.cfg.alarm_sel = v[2:0];
        OFS_ALMHI: next_st.cfg.alarm_hi = lim(v[15:0], FULL_SCALE);
        OFS_ALMLO: next_st.cfg.alarm_lo = lim(v[15:0], FULL_SCALE);
        OFS_STOPF: next_st.cfg.stop_f = lim(v[15:0], FULL_SCALE);
        OFS_LAT: next_st.cfg.latency = v[15:0];
        OFS_RESTF: next_st.cfg.restart_f = lim(v[15:0], FULL_SCALE);
        OFS_DOFUNC: next_st.cfg.do_func = v[15:0];
        OFS_IRQ_STAT: w1c = st.wdata[2:0] & {3{st.wstrb[0]}};
        OFS_IRQ_MASK: next_st.cfg.run_en = next_st.cfg.run_en;
        default: next_st.bresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
      endcase
      if (st.waddr == OFS_IRQ_MASK) begin
        next_st.irq_mask = v[2:0];
      end
    end
    if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end
    // Read channel
    if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = reg_read(st, axi_req.araddr)[31:0];
      next_st.rresp = reg_read(st, axi_req.araddr)[32] ? RESP_OKAY : RESP_SLVERR;
    end
    // Sample period
    if (st.tick_cnt >= 32'(SAMPLE_CYCLES_P - 1)) begin
      next_st.tick_cnt = '0;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 32'h00000001;
    end
    // Regulator sequence, once per sample
    unique case (st.phase)
      PH_IDLE: begin
        if (st.tick_cnt == '0) begin
          delta = $signed({2'b00, st.fb_s2}) - $signed({2'b00, st.filt[31:16]});
          dmag = delta[17] ? 17'(-delta) : delta[16:0];
          if (st.cfg.filt == '0) begin
            next_st.filt = {st.fb_s2, 16'h0000};
            next_st.phase = PH_ERR;
          end else begin
            // Step by delta * Ts / Tf
            next_st.neg = delta[17];
            next_st.div_num = {15'h0000, dmag, 16'h0000};
            next_st.div_den = 32'(st.cfg.filt) * 32'(SAMPLES_PER_TENTH);
            next_st.div_start = 1'b1;
            next_st.phase = PH_FWAIT;
          end
        end
      end
      PH_FWAIT: begin
        if (div_done) begin
          next_st.filt = st.neg ? st.filt - div_q[31:0] : st.filt + div_q[31:0];
          next_st.phase = PH_ERR;
        end
      end
      PH_ERR: begin
        e_n = $signed({2'b00, process_command_value}) - $signed({2'b00, st.filt[31:16]});
        emag = e_n[17] ? 18'(-e_n) : e_n;
        de = 19'(e_n) - 19'(st.err_prev);
        next_st.err_prev = e_n;
        p64 = 64'(signed'({1'b0, st.cfg.gain})) * 64'(e_n) / GAIN_DIV;
        d64 = 64'(signed'({1'b0, st.cfg.gain})) * 64'(signed'({1'b0, st.cfg.dtime}))
              * 64'(de) * SAMPLES_PER_HUNDREDTH / GAIN_DIV;
        next_st.pd_sum = p64 + d64;
        // Integrator frozen outside the windup band
        if (st.cfg.itime == '0) begin
          iacc_n = '0;
        end else if (emag <= 18'(st.cfg.windup) * WINDUP_TO_ERR) begin
          isum = st.iacc + 40'(e_n);
          iacc_n = (isum > IACC_LIM) ? IACC_LIM : (isum < -IACC_LIM) ? -IACC_LIM : isum;
        end
        next_st.iacc = iacc_n;
        imag = iacc_n[39] ? 40'(-iacc_n) : 40'(iacc_n);
        if (st.cfg.itime == '0) begin
          next_st.iterm = '0;
          next_st.phase = PH_OUT;
        end else begin
          next_st.neg = iacc_n[39];
          next_st.div_num = 48'(imag[31:0]) * 48'(st.cfg.gain);
          next_st.div_den = 32'(st.cfg.itime) * ITIME_DEN;
          next_st.div_start = 1'b1;
          next_st.phase = PH_IWAIT;
        end
      end
      PH_IWAIT: begin
        if (div_done) begin
          next_st.iterm = st.neg ? -$signed({16'h0000, div_q}) : $signed({16'h0000, div_q});
          next_st.phase = PH_OUT;
        end
      end
      PH_OUT: begin
        s64 = st.pd_sum + st.iterm;
        if (s64[63]) begin
          mv_n = '0;
        end else if (s64 > $signed({48'h0000, FULL_SCALE})) begin
          mv_n = FULL_SCALE;
        end else begin
          mv_n = s64[15:0];
        end
        next_st.mv = mv_n;
        // Slow flow stop with restart hysteresis
        eff_stop = (st.cfg.restart_f < st.cfg.stop_f) ? st.cfg.restart_f : st.cfg.stop_f;
        if (!st.stopped) begin
          if (mv_n < eff_stop) begin
            if (st.lat_cnt >= 32'(st.cfg.latency) * 32'(SAMPLES_PER_TENTH)) begin
              next_st.stopped = 1'b1;
              next_st.lat_cnt = '0;
              ev[1] = 1'b1;
            end else begin
              next_st.lat_cnt = st.lat_cnt + 32'h00000001;
            end
          end else begin
            next_st.lat_cnt = '0;
          end
        end else if (mv_n > st.cfg.restart_f) begin
          next_st.stopped = 1'b0;
          ev[2] = 1'b1;
        end
        next_st.phase = PH_IDLE;
      end
      default: next_st.phase = PH_IDLE;
    endcase
    // Sticky events; a new event wins over its clear
    next_st.alarm_prev = alarm;
    ev[0] = alarm && !st.alarm_prev;
    next_st.irq_stat = (st.irq_stat & ~w1c) | ev;
  end
  // ==================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st <= '0;
      st.cfg <= CFG_RST;
    end else begin
      st <= next_st;
    end
  end
  // ==================================================
  // Outputs
  generate
    for (genvar k = 0; k < DO_COUNT; k++) begin : g_do
      // Terminal function select
      assign do_terminal[k] = ((st.cfg.do_func[k] == DO_FUNC_ALARM) && st.alarm_prev)
                           || ((st.cfg.do_func[k] == DO_FUNC_STOP) && st.stopped);
    end
  endgenerate
  assign regulator_output_value = st.mv;
  assign drive_run = st.cfg.run_en && !st.stopped;
  assign process_alarm_output = st.alarm_prev;
  assign slow_flow_stopped_flag = st.stopped;
  assign irq = |(st.irq_stat & st.irq_mask);
  assign axi_rsp.awready = aw_rdy;
  assign axi_rsp.wready = w_rdy;
  assign axi_rsp.bvalid = st.bvalid;
  assign axi_rsp.bresp = st.bresp;
  assign axi_rsp.arready = !st.rvalid;
  assign axi_rsp.rvalid = st.rvalid;
  assign axi_rsp.rdata = st.rdata;
  assign axi_rsp.rresp = st.rresp;
endmodule

// ==== dv/pidc_plant.sv ====
`timescale 1ns/1ps
// ==================================================
// Feedback sensor model: presents a level one cycle late
module pidc_plant (
  input wire logic core_clk,
  input wire logic [15:0] level,
  output logic [15:0] process_feedback_value
);
  // Sensor output follows the commanded level
  always_ff @(posedge core_clk) begin
    process_feedback_value <= level;
  end
endmodule

// ==== dv/pidc_top_asserts.sv ====
`timescale 1ns/1ps
// ==================================================
// Port checker for the regulator top
module pidc_chk
  import pidc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input pidc_pkg::pidc_axi_req_t axi_req,
  input pidc_pkg::pidc_axi_rsp_t axi_rsp,
  input wire logic [15:0] regulator_output_value,
  input wire logic drive_run,
  input wire logic process_alarm_output,
  input wire logic slow_flow_stopped_flag,
  input wire logic [1:0] do_terminal,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_stop_gate: assert property (slow_flow_stopped_flag |-> !drive_run)
    else $error("drive runs while stopped");
  a_term_alarm: assert property (do_terminal[0] |-> process_alarm_output || slow_flow_stopped_flag)
    else $error("terminal 0 without source");
  a_term_stop: assert property (do_terminal[1] |-> process_alarm_output || slow_flow_stopped_flag)
    else $error("terminal 1 without source");
  a_out_bound: assert property (regulator_output_value <= FULL_SCALE)
    else $error("output above full scale");
  a_out_hold: assert property ($changed(regulator_output_value) |=> $stable(regulator_output_value)[*8])
    else $error("output changed twice in a sample");
  a_reset_quiet: assert property ($fell(reset) |-> !process_alarm_output && !slow_flow_stopped_flag)
    else $error("flags set after reset");
  a_b_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
    else $error("bvalid dropped");
  a_r_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
  a_ar_block: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("arready during rvalid");
  a_aw_block: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write ready during bvalid");
endmodule
bind pidc_top pidc_chk i_chk(.core_clk(core_clk), .reset(reset), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .regulator_output_value(regulator_output_value), .drive_run(drive_run),
  .process_alarm_output(process_alarm_output), .slow_flow_stopped_flag(slow_flow_stopped_flag),
  .do_terminal(do_terminal), .irq(irq));

// ==== dv/pidc_tb_top.sv ====
`timescale 1ns/1ps
module pidc_tb_top;
  import pidc_pkg::*;
  logic core_clk = 0;
  logic reset = 1;
  logic rcmd = 0;
  logic [15:0] cmd = 0;
  logic [15:0] lvl = 0;
  logic [15:0] fb, mv;
  logic run, alm, stp, irq;
  logic [1:0] dot, rr;
  logic [31:0] rd;
  pidc_axi_req_t rq;
  pidc_axi_rsp_t rs;
  int n_fail = 0;
  int checked = 0;
  always #4 core_clk = ~core_clk;
  pidc_plant i_plant(.core_clk(core_clk), .level(lvl), .process_feedback_value(fb));
  pidc_top #(.SAMPLE_CYCLES_P(200)) i_dut(.core_clk(core_clk), .reset(reset), .axi_req(rq),
    .axi_rsp(rs), .process_command_value(cmd), .process_feedback_value(fb),
    .reset_command(rcmd), .regulator_output_value(mv), .drive_run(run),
    .process_alarm_output(alm), .slow_flow_stopped_flag(stp), .do_terminal(dot), .irq(irq));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    rq.awaddr <= a;
    rq.wdata <= d;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (rs.awready) rq.awvalid <= 1'b0;
      if (rs.wready) rq.wvalid <= 1'b0;
    end while (rq.awvalid || rq.wvalid);
    do @(posedge core_clk); while (!rs.bvalid);
    rr = rs.bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    do @(posedge core_clk); while (!rs.arready);
    rq.arvalid <= 1'b0;
    do @(posedge core_clk); while (!rs.rvalid);
    rd = rs.rdata;
    rr = rs.rresp;
  endtask
  // Alarm with terminals: level in, then {terminals, alarm}
  task automatic al(input logic [15:0] l, input logic [2:0] e);
    lvl <= l;
    // Filtered feedback moves only at a sample tick, so wait past one period
    tk(250);
    chk("alarm", 32'(e), 32'({dot, alm}));
  endtask
  task automatic t_alarm;
    wr(OFS_DOFUNC, 32'h00002C2A);
    wr(OFS_ALMHI, 32'd8000);
    wr(OFS_ALMLO, 32'd2000);
    al(16'd9000, 3'b011);
    al(16'd1000, 3'b011);
    al(16'd5000, 3'b000);
    wr(OFS_ALMSEL, 32'd2);
    al(16'd9000, 3'b011);
    al(16'd5000, 3'b011);
    rcmd <= 1'b1;
    al(16'd5000, 3'b000);
    rcmd <= 1'b0;
    wr(OFS_ALMSEL, 32'd4);
    cmd <= 16'd5000;
    wr(OFS_ALMHI, 32'd1000);
    wr(OFS_ALMLO, 32'd1000);
    al(16'd6500, 3'b011);
    al(16'd3500, 3'b011);
    al(16'd5500, 3'b000);
  endtask
  task automatic t_slow;
    wr(OFS_GAIN, 32'h0000FFFF);
    rdr(OFS_GAIN);
    chk("gain clamp", 32'(GAIN_MAX), rd);
    wr(OFS_WINDUP, 32'h0000FFFF);
    rdr(OFS_WINDUP);
    chk("windup clamp", 32'(WINDUP_MAX), rd);
    rdr(8'h44);
    chk("unmapped", 32'(RESP_SLVERR), 32'(rr));
    wr(OFS_IRQ_MASK, 32'd2);
    wr(OFS_STOPF, 32'd1000);
    wr(OFS_RESTF, 32'd2000);
    wr(OFS_GAIN, 32'd0);
    wr(OFS_CTRL, 32'd1);
    tk(600);
    chk("stop", 32'h0000000D, 32'({dot[1], stp, run, irq}));
    wr(OFS_GAIN, 32'd1000);
    lvl <= 16'd0;
    tk(600);
    chk("restart", 32'h1, 32'({stp, run}));
    chk("output", 32'd5000, 32'(mv));
    wr(OFS_IRQ_STAT, 32'd7);
    chk("irq clear", 32'h0, 32'(irq));
    wr(OFS_RESTF, 32'd500);
    cmd <= 16'd700;
    tk(600);
    chk("below stop", 32'h1, 32'({stp, run}));
    cmd <= 16'd300;
    tk(600);
    chk("below restart", 32'h2, 32'({stp, run}));
  endtask
  task automatic end_sim;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rq = '0;
    rq.wstrb = 4'hF;
    rq.bready = 1'b1;
    rq.rready = 1'b1;
    tk(16);
    reset <= 1'b0;
    tk(1);
    t_alarm;
    t_slow;
    end_sim;
  end
  initial begin
    tk(20000);
    n_fail++;
    end_sim;
  end
endmodule
